// file: rtl/ccw_pkg.sv
// Constants for the write-only two-wire control port of the audio codec.
// Assumes a single 40 MHz system clock that oversamples the serial link.
package ccw_pkg;

    // ****************************************************************
    // Slave addresses
    // ****************************************************************
    localparam logic [6:0] CCW_SLAVE_ADDR_LOW = 7'h1A;
    localparam logic [6:0] CCW_SLAVE_ADDR_HIGH = 7'h1B;

    // ****************************************************************
    // Control register addresses and storage indices
    // ****************************************************************
    localparam logic [6:0] CCW_OFS_LEFT_LINE_IN_VOLUME = 7'h00;
    localparam logic [6:0] CCW_OFS_RIGHT_LINE_IN_VOLUME = 7'h01;
    localparam logic [6:0] CCW_OFS_LEFT_HEADPHONE_LEVEL = 7'h02;
    localparam logic [6:0] CCW_OFS_RIGHT_HEADPHONE_LEVEL = 7'h03;
    localparam logic [6:0] CCW_OFS_ANALOG_PATH_SETUP = 7'h04;
    localparam logic [6:0] CCW_OFS_DIGITAL_PATH_SETUP = 7'h05;
    localparam logic [6:0] CCW_OFS_POWER_DOWN_SETUP = 7'h06;
    localparam logic [6:0] CCW_OFS_AUDIO_PORT_FORMAT = 7'h07;
    localparam logic [6:0] CCW_OFS_SAMPLE_RATE_SETUP = 7'h08;
    localparam logic [6:0] CCW_OFS_AUDIO_PORT_ACTIVATION = 7'h09;
    localparam logic [6:0] CCW_OFS_SOFT_RESET_TRIGGER = 7'h0F;
    localparam int CCW_NUM_REGS = 11;
    localparam int CCW_NUM_CTRL_REGS = 10;
    localparam logic [3:0] CCW_IDX_SOFT_RESET = 4'hA;
    localparam logic [3:0] CCW_IDX_NONE = 4'hF;

    // ****************************************************************
    // Reset values and framing
    // ****************************************************************
    localparam logic [8:0] CCW_CTRL_RESET = 9'h000;
    localparam logic [3:0] CCW_BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] CCW_BYTE_ADDR = 2'h0;
    localparam logic [1:0] CCW_BYTE_HIGH = 2'h1;
    localparam logic [1:0] CCW_BYTE_LOW = 2'h2;

    typedef enum logic [1:0] {
        CCW_ST_IDLE = 2'b00,
        CCW_ST_RECV = 2'b01,
        CCW_ST_ACK = 2'b10,
        CCW_ST_IGNORE = 2'b11
    } ccw_state_e;

endpackage

// file: rtl/ccw_control_write_port.sv
// Write-only two-wire control slave holding eleven 9-bit registers.
// Assumes the master drives the serial clock and that the data wire is
// resolved outside from the output enable; both pins are asynchronous.
//
// Notes on behaviour
// [R1] A falling data line while the clock is high starts a transfer.
// [R2] Seven address bits and then a direction bit follow the start.
// [R3] Only writes are answered; a read request is ignored entirely.
// [R4] The slave address is 0011010 with the select pin low, else 0011011.
// [R5] The select pin defaults low, giving address 0x1A.
// [R6] On an address match the data line is pulled low in the ninth clock.
// [R7] The master sends the control word as two bytes after the address.
// [R8] A rising data line while the clock is high ends the transfer.
// [R9] Word bits 15 to 9 pick the register and bits 8 to 0 are its value.
// [R10] Addresses 0 to 9 and 15 are decoded; others have no effect (the code still pulses wr_stb_o with their address and data).
// [R11] Each control byte is acknowledged; the write lands after byte two.
// [R12] Bytes arrive most significant bit first; data moves at clock low.
`timescale 1ns/1ps

module ccw_control_write_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic serial_data_line_i,
    input wire logic addr_sel_i,
    output logic serial_data_line_o,
    output logic serial_data_line_oe_o,
    output logic [8:0] left_line_in_volume_o,
    output logic [8:0] right_line_in_volume_o,
    output logic [8:0] left_headphone_level_o,
    output logic [8:0] right_headphone_level_o,
    output logic [8:0] analog_path_setup_o,
    output logic [8:0] digital_path_setup_o,
    output logic [8:0] power_down_setup_o,
    output logic [8:0] audio_port_format_o,
    output logic [8:0] sample_rate_setup_o,
    output logic [8:0] audio_port_activation_o,
    output logic [8:0] soft_reset_trigger_o,
    output logic wr_stb_o,
    output logic [6:0] wr_addr_o,
    output logic [8:0] wr_data_o,
    output logic soft_reset_o
);
    import ccw_pkg::*;

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    logic [2:0] scl_sync_reg, scl_sync_next;
    logic [2:0] sda_sync_reg, sda_sync_next;
    logic [1:0] sel_sync_reg, sel_sync_next;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_comb begin
        scl_sync_next = {scl_sync_reg[1:0], scl_i};
        sda_sync_next = {sda_sync_reg[1:0], serial_data_line_i};
        sel_sync_next = {sel_sync_reg[0], addr_sel_i};
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            sel_sync_reg <= 2'h0; // R5
        end else begin
            scl_sync_reg <= scl_sync_next;
            sda_sync_reg <= sda_sync_next;
            sel_sync_reg <= sel_sync_next;
        end
    end

    assign scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
    assign scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
    // Both clock samples must be high so a clock edge is never read as one.
    assign start_det = scl_sync_reg[1] & scl_sync_reg[2] &
                       ~sda_sync_reg[1] & sda_sync_reg[2]; // R1
    assign stop_det = scl_sync_reg[1] & scl_sync_reg[2] &
                      sda_sync_reg[1] & ~sda_sync_reg[2]; // R8

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic [3:0] reg_index(input logic [6:0] a);
        logic [3:0] idx;
        idx = CCW_IDX_NONE;
        unique case (a)
            CCW_OFS_LEFT_LINE_IN_VOLUME: idx = 4'h0;
            CCW_OFS_RIGHT_LINE_IN_VOLUME: idx = 4'h1;
            CCW_OFS_LEFT_HEADPHONE_LEVEL: idx = 4'h2;
            CCW_OFS_RIGHT_HEADPHONE_LEVEL: idx = 4'h3;
            CCW_OFS_ANALOG_PATH_SETUP: idx = 4'h4;
            CCW_OFS_DIGITAL_PATH_SETUP: idx = 4'h5;
            CCW_OFS_POWER_DOWN_SETUP: idx = 4'h6;
            CCW_OFS_AUDIO_PORT_FORMAT: idx = 4'h7;
            CCW_OFS_SAMPLE_RATE_SETUP: idx = 4'h8;
            CCW_OFS_AUDIO_PORT_ACTIVATION: idx = 4'h9;
            CCW_OFS_SOFT_RESET_TRIGGER: idx = CCW_IDX_SOFT_RESET;
            default: idx = CCW_IDX_NONE;
        endcase
        return idx;
    endfunction

    // ****************************************************************
    // Link receiver
    // ****************************************************************
    ccw_state_e state_reg, state_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [1:0] byte_idx_reg, byte_idx_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] word_hi_reg, word_hi_next;
    logic oe_reg, oe_next;
    logic [6:0] own_addr;
    logic byte_done, commit;
    logic [6:0] commit_addr;
    logic [8:0] commit_data;

    assign own_addr = sel_sync_reg[1] ? CCW_SLAVE_ADDR_HIGH :
                                        CCW_SLAVE_ADDR_LOW; // R4
    assign byte_done = (state_reg == CCW_ST_RECV) && scl_fall &&
                       (bit_cnt_reg == CCW_BITS_PER_BYTE);
    assign commit = byte_done && (byte_idx_reg == CCW_BYTE_LOW); // R11
    assign commit_addr = word_hi_reg[7:1]; // R9
    assign commit_data = {word_hi_reg[0], shift_reg}; // R9

    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        byte_idx_next = byte_idx_reg;
        shift_next = shift_reg;
        word_hi_next = word_hi_reg;
        oe_next = oe_reg;
        if (stop_det) begin
            state_next = CCW_ST_IDLE; // R8
            oe_next = 1'b0;
        end else if (start_det) begin
            state_next = CCW_ST_RECV; // R1
            bit_cnt_next = 4'h0;
            byte_idx_next = CCW_BYTE_ADDR;
            oe_next = 1'b0;
        end else begin
            unique case (state_reg)
                CCW_ST_IDLE: begin
                    oe_next = 1'b0;
                end
                CCW_ST_RECV: begin
                    if (scl_rise && bit_cnt_reg != CCW_BITS_PER_BYTE) begin
                        shift_next = {shift_reg[6:0], sda_sync_reg[1]}; // R12
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    if (byte_done) begin
                        state_next = CCW_ST_ACK;
                        oe_next = 1'b1; // R11
                        unique case (byte_idx_reg)
                            CCW_BYTE_ADDR: begin
                                // Address in bits 7..1, direction in bit 0.
                                if (shift_reg[7:1] != own_addr ||
                                    shift_reg[0]) begin // R2
                                    state_next = CCW_ST_IGNORE; // R3
                                    oe_next = 1'b0;
                                end
                            end
                            CCW_BYTE_HIGH: begin
                                word_hi_next = shift_reg; // R7
                            end
                            CCW_BYTE_LOW: begin
                            end
                            default: begin
                                // Extra bytes past the word are refused.
                                state_next = CCW_ST_IGNORE;
                                oe_next = 1'b0;
                            end
                        endcase
                    end
                end
                CCW_ST_ACK: begin
                    if (scl_fall) begin
                        oe_next = 1'b0; // R6
                        state_next = CCW_ST_RECV;
                        bit_cnt_next = 4'h0;
                        byte_idx_next = byte_idx_reg + 2'h1;
                    end
                end
                CCW_ST_IGNORE: begin
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= CCW_ST_IDLE;
            bit_cnt_reg <= 4'h0;
            byte_idx_reg <= 2'h0;
            shift_reg <= 8'h00;
            word_hi_reg <= 8'h00;
            oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            byte_idx_reg <= byte_idx_next;
            shift_reg <= shift_next;
            word_hi_reg <= word_hi_next;
            oe_reg <= oe_next;
        end
    end

    // The wire only ever goes low; the pull-up makes the high level.
    assign serial_data_line_o = 1'b0; // R6
    assign serial_data_line_oe_o = oe_reg;

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [8:0] regs_reg [0:CCW_NUM_REGS-1];
    logic [8:0] regs_next [0:CCW_NUM_REGS-1];
    logic [3:0] commit_idx;
    logic wr_stb_reg, wr_stb_next;
    logic [6:0] wr_addr_reg, wr_addr_next;
    logic [8:0] wr_data_reg, wr_data_next;
    logic soft_reset_reg, soft_reset_next;

    assign commit_idx = reg_index(commit_addr);

    always_comb begin
        regs_next = regs_reg;
        wr_stb_next = commit;
        wr_addr_next = wr_addr_reg;
        wr_data_next = wr_data_reg;
        soft_reset_next = 1'b0;
        if (commit) begin
            wr_addr_next = commit_addr;
            wr_data_next = commit_data;
            if (commit_idx == CCW_IDX_SOFT_RESET) begin // R10
                for (int i = 0; i < CCW_NUM_CTRL_REGS; i++) begin
                    regs_next[i] = CCW_CTRL_RESET;
                end
                regs_next[CCW_IDX_SOFT_RESET] = commit_data;
                soft_reset_next = 1'b1;
            end else if (commit_idx != CCW_IDX_NONE) begin // R10
                regs_next[commit_idx] = commit_data;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < CCW_NUM_REGS; i++) begin
                regs_reg[i] <= CCW_CTRL_RESET;
            end
            wr_stb_reg <= 1'b0;
            wr_addr_reg <= 7'h00;
            wr_data_reg <= 9'h000;
            soft_reset_reg <= 1'b0;
        end else begin
            regs_reg <= regs_next;
            wr_stb_reg <= wr_stb_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
            soft_reset_reg <= soft_reset_next;
        end
    end

    assign left_line_in_volume_o = regs_reg[0];
    assign right_line_in_volume_o = regs_reg[1];
    assign left_headphone_level_o = regs_reg[2];
    assign right_headphone_level_o = regs_reg[3];
    assign analog_path_setup_o = regs_reg[4];
    assign digital_path_setup_o = regs_reg[5];
    assign power_down_setup_o = regs_reg[6];
    assign audio_port_format_o = regs_reg[7];
    assign sample_rate_setup_o = regs_reg[8];
    assign audio_port_activation_o = regs_reg[9];
    assign soft_reset_trigger_o = regs_reg[CCW_IDX_SOFT_RESET];
    assign wr_stb_o = wr_stb_reg;
    assign wr_addr_o = wr_addr_reg;
    assign wr_data_o = wr_data_reg;
    assign soft_reset_o = soft_reset_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [3:0] wr_idx;
    assign wr_idx = reg_index(wr_addr_reg);

    chk_start_enter: assert property ( // R1
        start_det && !stop_det |=> state_reg == CCW_ST_RECV &&
            bit_cnt_reg == 4'h0 && byte_idx_reg == CCW_BYTE_ADDR)
        else $error("start condition not taken");
    chk_stop_idle: assert property ( // R8
        stop_det |=> state_reg == CCW_ST_IDLE && !oe_reg)
        else $error("stop condition not taken");
    chk_read_ignored: assert property ( // R3
        byte_done && byte_idx_reg == CCW_BYTE_ADDR && shift_reg[0]
        |=> state_reg == CCW_ST_IGNORE && !oe_reg)
        else $error("read request was answered");
    chk_addr_ack: assert property ( // R4
        byte_done && byte_idx_reg == CCW_BYTE_ADDR && !shift_reg[0] &&
        !start_det && !stop_det &&
        shift_reg[7:1] == (sel_sync_reg[1] ? 7'h1B : 7'h1A)
        |=> oe_reg && state_reg == CCW_ST_ACK)
        else $error("matching address not acknowledged");
    chk_ack_release: assert property ( // R6
        state_reg == CCW_ST_ACK && scl_fall && !start_det && !stop_det
        |=> !oe_reg && state_reg == CCW_ST_RECV && bit_cnt_reg == 4'h0)
        else $error("acknowledge not released after ninth clock");
    chk_ack_low: assert property ( // R6
        oe_reg |-> !serial_data_line_o && (state_reg == CCW_ST_ACK ||
            $past(state_reg) == CCW_ST_ACK))
        else $error("data line driven outside acknowledge");
    chk_write_late: assert property ( // R11
        wr_stb_reg |-> $past(state_reg) == CCW_ST_RECV &&
            $past(byte_idx_reg) == CCW_BYTE_LOW && $past(scl_fall))
        else $error("write before second byte completed");
    chk_write_split: assert property ( // R9
        wr_stb_reg && wr_idx < CCW_IDX_SOFT_RESET
        |-> regs_reg[wr_idx] == wr_data_reg)
        else $error("register not loaded from word");
    chk_soft_reset: assert property ( // R10
        wr_stb_reg && wr_idx == CCW_IDX_SOFT_RESET
        |-> soft_reset_reg && regs_reg[0] == CCW_CTRL_RESET)
        else $error("reset register write had no effect");
    chk_msb_first: assert property ( // R12
        state_reg == CCW_ST_RECV && scl_rise && bit_cnt_reg < 4'h8 &&
        !start_det && !stop_det
        |=> shift_reg[0] == $past(sda_sync_reg[1]) &&
            shift_reg[7:1] == $past(shift_reg[6:0]))
        else $error("bit not shifted in at the low end");
    cov_full_write: cover property (wr_stb_reg && wr_idx < 4'hA);
    cov_read_refused: cover property (
        byte_done && byte_idx_reg == CCW_BYTE_ADDR && shift_reg[0]);
    cov_soft_reset: cover property (soft_reset_reg);

endmodule

// file: tb/ccw_master_model.sv
// Behavioural two-wire bus master that writes the control port.
// Assumes the bench resolves the data wire with a pull-up and that
// only one process at a time calls these tasks.
`timescale 1ns/1ps

module ccw_master_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // Half period of the serial clock in system clocks; 4 gives 100 ns.
    int half;

    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        half = 4;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Works from an idle bus and as a repeated start from a low clock.
    task automatic start_cond();
        sda_low_o = 1'b0;
        tick(half);
        scl_o = 1'b1;
        tick(half);
        sda_low_o = 1'b1;
        tick(half);
        scl_o = 1'b0;
        tick(1);
    endtask

    // Data moves one clock after the falling edge, never while high.
    task automatic send_bit(input logic b, output logic seen);
        sda_low_o = ~b;
        tick(half - 1);
        scl_o = 1'b1;
        tick(half / 2);
        seen = sda_i;
        tick(half - half / 2);
        scl_o = 1'b0;
        tick(1);
    endtask

    // Eight bits, most significant first, then a released ninth clock.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i], s);
        end
        send_bit(1'b1, s);
        ack = (s === 1'b0);
    endtask

    task automatic stop_cond();
        sda_low_o = 1'b1;
        tick(half - 1);
        scl_o = 1'b1;
        tick(half);
        sda_low_o = 1'b0;
        tick(half);
    endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the control write port.
// Assumes the master model drives the link; the wire has a pull-up.
`timescale 1ns/1ps

module tb_top;
    import ccw_pkg::*;

    typedef struct packed {
        logic [6:0] a;
        logic [8:0] d;
        logic s;
        logic [10:0][8:0] r;
    } ccw_note_s;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic addr_sel = 1'b0;
    logic scl, m_low, sda_o, sda_oe, wr_stb_o, soft_reset_o;
    logic sda_wire;
    logic [6:0] wr_addr_o;
    logic [8:0] wr_data_o;
    logic [8:0] r0, r1, r2, r3, r4, r5, r6, r7, r8, r9, r15;
    logic [10:0][8:0] seen;
    logic [10:0][8:0] exp_regs = '0;
    ccw_note_s notes[$];
    int errors = 0;
    int num_checks = 0;
    int seed = 20506;

    always #12.5 clk_i = ~clk_i;
    assign sda_wire = !(m_low || (sda_oe === 1'b1 && sda_o === 1'b0));
    assign seen = {r15, r9, r8, r7, r6, r5, r4, r3, r2, r1, r0};

    ccw_master_model m (.clk_i(clk_i), .sda_i(sda_wire), .scl_o(scl),
        .sda_low_o(m_low));

    ccw_control_write_port uut (.clk_i(clk_i), .rst_i(rst_i),
        .scl_i(scl), .serial_data_line_i(sda_wire), .addr_sel_i(addr_sel),
        .serial_data_line_o(sda_o), .serial_data_line_oe_o(sda_oe),
        .left_line_in_volume_o(r0), .right_line_in_volume_o(r1),
        .left_headphone_level_o(r2), .right_headphone_level_o(r3),
        .analog_path_setup_o(r4), .digital_path_setup_o(r5),
        .power_down_setup_o(r6), .audio_port_format_o(r7),
        .sample_rate_setup_o(r8), .audio_port_activation_o(r9),
        .soft_reset_trigger_o(r15), .wr_stb_o(wr_stb_o),
        .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
        .soft_reset_o(soft_reset_o));

    // ****************************************************************
    // Comparison, verdict and watchdog
    // ****************************************************************
    task automatic check(input logic [98:0] got, input logic [98:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t ns: got %0h expected %0h",
                $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        errors++;
        summarize();
    end

    // Each commit strobe takes the oldest note and compares everything.
    always @(negedge clk_i) begin
        ccw_note_s n;
        if (wr_stb_o === 1'b1) begin
            if (notes.size() == 0) begin
                check(1'b1, 1'b0);
            end else begin
                n = notes.pop_front();
                check(wr_addr_o, n.a);
                check(wr_data_o, n.d);
                check(soft_reset_o, n.s);
                check(seen, n.r);
            end
        end
    end

    // ****************************************************************
    // Bus transfers
    // ****************************************************************
    function automatic logic [6:0] dev_addr(input logic sel);
        return sel ? 7'h1B : 7'h1A;
    endfunction

    task automatic frame(input logic [7:0] ab, input logic [15:0] w,
        input int nb, input logic [3:0] e);
        logic ack;
        m.start_cond();
        m.send_byte(ab, ack);
        check(ack, e[0]);
        for (int k = 0; k < nb; k++) begin
            m.send_byte(k == 0 ? w[15:8] : (k == 1 ? w[7:0] : 8'hA5), ack);
            check(ack, e[k + 1]);
        end
        m.stop_cond();
        m.tick(4);
        check(sda_oe, 1'b0);
    endtask

    task automatic write_reg(input logic [6:0] a, input logic [8:0] d,
        input int nb);
        if (a == 7'h0F) begin
            exp_regs = '0;
            exp_regs[10] = d;
        end else if (a <= 7'h09) begin
            exp_regs[a[3:0]] = d;
        end
        notes.push_back({a, d, a == 7'h0F, exp_regs});
        frame({dev_addr(addr_sel), 1'b0}, {a, d}, nb, 4'b0111);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        logic ack;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        m.tick(8);
        check(seen, exp_regs);
        check(sda_oe, 1'b0);
        for (int i = 0; i < 10; i++) begin
            addr_sel = i[0];
            m.tick(8);
            write_reg(i[6:0], 9'($random(seed)), 2);
        end
        frame({dev_addr(~addr_sel), 1'b0}, 16'h0355, 2, 4'b0000);
        frame({dev_addr(addr_sel), 1'b1}, 16'h0355, 2, 4'b0000);
        write_reg(7'h0A, 9'($random(seed)), 2);
        write_reg(7'h19, 9'($random(seed)), 2);
        write_reg(7'h02, 9'($random(seed)), 3);
        frame({dev_addr(addr_sel), 1'b0}, 16'h0777, 1, 4'b0011);
        m.start_cond();
        m.send_byte({dev_addr(addr_sel), 1'b0}, ack);
        check(ack, 1'b1);
        m.send_byte(8'h08, ack);
        check(ack, 1'b1);
        write_reg(7'h07, 9'($random(seed)), 2);
        m.half = 8;
        write_reg(7'h05, 9'($random(seed)), 2);
        m.half = 4;
        write_reg(7'h0F, 9'($random(seed)), 2);
        // A reset in mid-run clears every register.
        rst_i = 1'b1;
        m.tick(2);
        rst_i = 1'b0;
        exp_regs = '0;
        m.tick(8);
        check(seen, exp_regs);
        write_reg(7'h03, 9'($random(seed)), 2);
        m.tick(20);
        check(notes.size() == 0, 1'b1);
        summarize();
    end
endmodule
